// [hw/ebc_ext_bus_ctrl.v]
`timescale 1ns/1ps
`include "ebc_regs.vh"
module ebc_ext_bus_ctrl #(
  parameter AW = 24,
  parameter DW = 16
) (
  // clock, reset, enable
  input  wire          core_clk,
  input  wire          rst,
  input  wire          clkEn,
  // core request side
  input  wire          reqValid,
  input  wire          reqWrite,
  input  wire          reqByte,
  input  wire [AW-1:0] reqAddr,
  input  wire [DW-1:0] reqWdata,
  output reg           reqDone,
  output reg  [DW-1:0] reqRdata,
  output reg           reqBusy,
  // configuration bits
  input  wire [15:0]   default_bus_config,
  input  wire [15:0]   window1_bus_config,
  input  wire [15:0]   window2_bus_config,
  input  wire [15:0]   window3_bus_config,
  input  wire [15:0]   window4_bus_config,
  input  wire [15:0]   window1_range_select,
  input  wire [15:0]   window2_range_select,
  input  wire [15:0]   window3_range_select,
  input  wire [15:0]   window4_range_select,
  input  wire [1:0]    addrSpaceSel,
  input  wire          select_timing_cfg,
  input  wire          arbitration_enable,
  input  wire          ack_pin_direction,
  // external bus pins
  output reg  [15:0]   addrDataOut,
  output reg  [15:0]   addrDataOe,
  input  wire [15:0]   addrDataIn,
  output reg  [15:0]   address_port,
  output reg  [7:0]    segAddr,
  output reg           aleOut,
  output reg           rdN,
  output reg           wrN,
  output reg  [4:0]    window_chip_select_n,
  input  wire          readyIn,
  // arbitration pins
  input  wire          holdN,
  output reg           bus_hold_ackOut,
  output reg           bus_hold_ackOe,
  input  wire          bus_hold_ackIn,
  output reg           bus_request_out,
  output reg           busFloat
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h0; // waiting
  localparam ST_ADDR = 3'h1; // address phase, strobe high
  localparam ST_DLY  = 3'h2; // strobe delay
  localparam ST_DATA = 3'h3; // strobe active
  localparam ST_TRI  = 3'h4; // tristate recovery
  localparam ST_HOLD = 3'h5; // bus given away

  reg  [2:0]  state_r;     // state register
  reg  [3:0]  cnt_r;       // phase counter
  reg  [15:0] cfg_r;       // latched config of running cycle
  reg  [4:0]  csSel_r;     // chip select vector of cycle
  reg  [4:0]  csDly_r;     // half-cycle delayed select
  reg         writeCyc_r;  // cycle is a write
  reg         byteCyc_r;   // cycle is a byte access
  reg  [15:0] wdata_r;     // write data held
  reg  [AW-1:0] addr_r;    // address held

  // ------------------------------------------------------------
  // synchronisers for external inputs
  // ------------------------------------------------------------
  wire readySync;  // ready pin
  wire holdSync;   // hold pin, high while hold is asserted
  wire ackSync;    // ack pin in slave role, high while asserted
  // active-low pins enter inverted: a chain cleared by reset reads idle,
  // so no false hold or grant shows in the first cycles after reset

  ebc_sync3 uRdy (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
                  .pinIn(readyIn), .pinOut(readySync));
  ebc_sync3 uHld (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
                  .pinIn(~holdN), .pinOut(holdSync));
  ebc_sync3 uAck (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
                  .pinIn(~bus_hold_ackIn), .pinOut(ackSync));

  // ------------------------------------------------------------
  // window match function
  // ------------------------------------------------------------
  // range word: base in 4 KB units, size code gives 4 KB << code
  function inRange;
    input [15:0]   rng;
    input [AW-1:0] a;
    reg   [23:0]   mask;
    reg   [23:0]   base;
    reg   [23:0]   aw;
    begin
      mask = 24'hfff000 << rng[15:`EBC_RNG_SIZE_LO];
      base = {rng[`EBC_RNG_BASE_HI:0], 12'h000};
      aw   = a;
      inRange = ((aw & mask) == (base & mask));
    end
  endfunction

  // ------------------------------------------------------------
  // window selection
  // ------------------------------------------------------------
  reg [15:0] selCfg; // chosen config
  reg [4:0]  selCs;  // chosen select, bit0 default
  reg        hit1, hit2, hit3, hit4;
  always @* begin
    hit1 = window1_bus_config[`EBC_CFG_EN_BIT] & inRange(window1_range_select, reqAddr);
    hit2 = window2_bus_config[`EBC_CFG_EN_BIT] & inRange(window2_range_select, reqAddr);
    hit3 = window3_bus_config[`EBC_CFG_EN_BIT] & inRange(window3_range_select, reqAddr);
    hit4 = window4_bus_config[`EBC_CFG_EN_BIT] & inRange(window4_range_select, reqAddr);
    // four over three over two over one; highest window number wins
    if (hit4) begin
      selCfg = window4_bus_config;
      selCs  = 5'h10;
    end else if (hit3) begin
      selCfg = window3_bus_config;
      selCs  = 5'h08;
    end else if (hit2) begin
      selCfg = window2_bus_config;
      selCs  = 5'h04;
    end else if (hit1) begin
      selCfg = window1_bus_config;
      selCs  = 5'h02;
    end else begin
      selCfg = default_bus_config;
      selCs  = 5'h01;
    end
  end

  // ------------------------------------------------------------
  // decoded fields of running cycle
  // ------------------------------------------------------------
  wire [1:0] cfgMode  = cfg_r[`EBC_CFG_MODE_LO+1:`EBC_CFG_MODE_LO];
  wire       cfgMux   = cfg_r[`EBC_CFG_MUX_BIT];
  wire [3:0] cfgMct   = cfg_r[`EBC_CFG_MCT_HI:`EBC_CFG_MCT_LO];
  wire       cfgMtt   = cfg_r[`EBC_CFG_MTT_BIT];
  wire       cfgAle   = cfg_r[`EBC_CFG_ALE_BIT];
  wire       cfgRwd   = cfg_r[`EBC_CFG_RWD_BIT];
  wire       cfgRdyEn = cfg_r[`EBC_CFG_RDYEN_BIT];
  wire       cfgRdyPl = cfg_r[`EBC_CFG_READY_POLARITY_BIT];
  wire       cfgCsEn  = cfg_r[`EBC_CFG_CSEN_BIT];
  wire       is8      = (cfgMode == `EBC_MODE_8BIT);
  wire       isMux    = (cfgMode == `EBC_MODE_MUX16) | (is8 & cfgMux);
  // ready seen at its configured level
  wire       rdyOk    = ~cfgRdyEn | (readySync == cfgRdyPl);
  // master role is default, slave when arbitration is enabled and direction bit set
  wire       slave    = arbitration_enable & ack_pin_direction;
  wire       holdReq  = arbitration_enable & holdSync & ~slave;
  // in slave role the bus is ours only while ack is asserted low by master
  wire       slaveGnt = ackSync;
  // mode of the config chosen for the pending request
  wire [1:0] selMode  = selCfg[`EBC_CFG_MODE_LO+1:`EBC_CFG_MODE_LO];
  wire       reqMode  = (selMode != `EBC_MODE_SINGLE);

  // segment lines per address space
  function [7:0] segMask;
    input [1:0] sp;
    begin
      case (sp)
        `EBC_SPACE_16M:  segMask = 8'hff;
        `EBC_SPACE_1M:   segMask = 8'h0f;
        `EBC_SPACE_256K: segMask = 8'h03;
        default:         segMask = 8'h00;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // bus cycle sequencer
  // ------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r         <= ST_IDLE;
      cnt_r           <= 4'h0;
      cfg_r           <= `EBC_CFG_RESET;
      csSel_r         <= 5'h00;
      writeCyc_r      <= 1'b0;
      byteCyc_r       <= 1'b0;
      wdata_r         <= 16'h0000;
      addr_r          <= {AW{1'b0}};
      reqDone         <= 1'b0;
      reqRdata        <= {DW{1'b0}};
      reqBusy         <= 1'b0;
      addrDataOut     <= 16'h0000;
      addrDataOe      <= 16'h0000;
      address_port    <= 16'h0000;
      segAddr         <= 8'h00;
      aleOut          <= 1'b0;
      rdN             <= 1'b1;
      wrN             <= 1'b1;
      bus_hold_ackOut <= 1'b1;
      bus_hold_ackOe  <= 1'b1;
      bus_request_out <= 1'b0;
      busFloat        <= 1'b0;
    end else if (clkEn) begin
      reqDone         <= 1'b0;
      bus_hold_ackOe  <= ~slave;
      bus_request_out <= slave & reqValid & ~slaveGnt;
      case (state_r)
        ST_IDLE: begin
          busFloat <= slave & ~slaveGnt;
          if (holdReq) begin
            addrDataOe      <= 16'h0000;
            busFloat        <= 1'b1;
            state_r         <= ST_HOLD;
          // requests wait while the bus is held or not yet granted
          end else if (reqValid & ~(slave & ~slaveGnt)) begin
            if (!reqMode) begin
              reqDone <= 1'b1;
              reqRdata <= {DW{1'b0}};
            end else begin
              cfg_r      <= selCfg;
              csSel_r    <= selCs & {5{selCfg[`EBC_CFG_CSEN_BIT]}};
              writeCyc_r <= reqWrite;
              byteCyc_r  <= reqByte;
              wdata_r    <= reqWdata;
              addr_r     <= reqAddr;
              reqBusy    <= 1'b1;
              aleOut     <= 1'b1;
              cnt_r      <= {3'h0, selCfg[`EBC_CFG_ALE_BIT]};
              segAddr    <= reqAddr[23:16] & segMask(addrSpaceSel);
              address_port <= reqAddr[15:0];
              state_r    <= ST_ADDR;
              // mux modes put address on the shared port
              if ((selMode == `EBC_MODE_MUX16) |
                  ((selMode == `EBC_MODE_8BIT) & selCfg[`EBC_CFG_MUX_BIT])) begin
                addrDataOut <= reqAddr[15:0];
                addrDataOe  <= 16'hffff;
              end
            end
          end
        end
        ST_ADDR: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            aleOut  <= 1'b0;
            cnt_r   <= {3'h0, cfgRwd};
            state_r <= ST_DLY;
            if (isMux) begin
              addrDataOe <= 16'h0000;
            end
            if (writeCyc_r) begin
              addrDataOut <= wdata_r;
              addrDataOe  <= is8 ? 16'h00ff : 16'hffff;
            end
          end
        end
        ST_DLY: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            rdN     <= writeCyc_r;
            wrN     <= ~writeCyc_r;
            cnt_r   <= cfgMct;
            state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (rdyOk) begin
            rdN      <= 1'b1;
            wrN      <= 1'b1;
            reqDone  <= 1'b1;
            reqBusy  <= 1'b0;
            reqRdata <= (is8 | byteCyc_r) ? {8'h00, addrDataIn[7:0]} : addrDataIn;
            addrDataOe <= 16'h0000;
            cnt_r    <= {3'h0, cfgMtt};
            state_r  <= ST_TRI;
          end
        end
        ST_TRI: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            csSel_r <= 5'h00;
            state_r <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          // acknowledge only after floating; drop with hold
          if (holdReq) begin
            bus_hold_ackOut <= 1'b0;
          end else begin
            bus_hold_ackOut <= 1'b1;
            busFloat        <= 1'b0;
            state_r         <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // chip select timing
  // ------------------------------------------------------------
  // half-cycle delay stage on falling edge
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      csDly_r <= 5'h00;
    end else if (clkEn) begin
      csDly_r <= csSel_r;
    end
  end

  // output select between the two flop stages; no gate in the path
  // fast mode follows the sequencer flop, so it moves with the rising ALE edge
  // default mode waits for the falling-edge copy, half a cycle later
  // switching the mode bit mid-cycle moves the select at once
  always @* begin
    if (select_timing_cfg) begin
      window_chip_select_n = ~csSel_r;
    end else begin
      window_chip_select_n = ~csDly_r;
    end
  end
endmodule

// [hw/ebc_regs.vh]
`ifndef EBC_REGS_VH
`define EBC_REGS_VH
// bus mode codes (mode field of a bus config word)
`define EBC_MODE_SINGLE    2'h0
`define EBC_MODE_DMX16     2'h1
`define EBC_MODE_MUX16     2'h2
`define EBC_MODE_8BIT      2'h3
// bus config word layout (16 bits)
`define EBC_CFG_MODE_LO    0
`define EBC_CFG_MUX_BIT    2
`define EBC_CFG_MCT_LO     3
`define EBC_CFG_MCT_HI     6
`define EBC_CFG_MTT_BIT    7
`define EBC_CFG_ALE_BIT    8
`define EBC_CFG_RWD_BIT    9
`define EBC_CFG_RDYEN_BIT  10
`define EBC_CFG_READY_POLARITY_BIT 11
`define EBC_CFG_CSEN_BIT   12
`define EBC_CFG_EN_BIT     13
// window range word: base [11:0] in 4 KB units, size code [15:12]
`define EBC_RNG_BASE_HI    11
`define EBC_RNG_SIZE_LO    12
// address space codes
`define EBC_SPACE_16M      2'h0
`define EBC_SPACE_1M       2'h1
`define EBC_SPACE_256K     2'h2
`define EBC_SPACE_64K      2'h3
// reset values
`define EBC_CFG_RESET      16'h0000
`define EBC_RNG_RESET      16'h0000
`endif

// [hw/ebc_sync3.v]
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module ebc_sync3 (
  // clock and reset
  input  wire core_clk,
  input  wire rst,
  input  wire clkEn,
  // data
  input  wire pinIn,
  output reg  pinOut
);
  reg [2:0] stage_r; // shift chain, bit0 is first stage

  // shift and filter
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage_r <= 3'h0;
      pinOut  <= 1'b0;
    end else if (clkEn) begin
      stage_r <= {stage_r[1:0], pinIn};
      if (stage_r[1] == stage_r[2]) begin
        pinOut <= stage_r[2];
      end
    end
  end
endmodule

// [sim/ebc_bus_asserts.sv]
`timescale 1ns/1ps
// ------------------------------------------
// port checker for the bus controller
// ------------------------------------------
module ebc_bus_asserts (
  // clock and reset
  input logic        core_clk,
  input logic        rst,
  // bus pins and settings
  input logic        reqDone,
  input logic        rdN,
  input logic        wrN,
  input logic        aleOut,
  input logic [15:0] addrDataOe,
  input logic [4:0]  window_chip_select_n,
  input logic [7:0]  segAddr,
  input logic [1:0]  addrSpaceSel,
  // arbitration
  input logic        holdN,
  input logic        busFloat,
  input logic        bus_hold_ackOut,
  input logic        bus_hold_ackOe,
  input logic        arbitration_enable,
  input logic        ack_pin_direction
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // one read or write strobe at a time
  strobe_excl_a: assert property (rdN || wrN)
    else $error("read and write strobes low together");
  // read data phase leaves the shared port free
  read_float_a: assert property (!rdN |-> addrDataOe == 16'h0000)
    else $error("port driven during read strobe");
  // address phase is over before any strobe
  ale_order_a: assert property (!(rdN && wrN) |-> !aleOut)
    else $error("address strobe overlaps data strobe");
  // at most one select active
  cs_single_a: assert property ($countones(~window_chip_select_n) <= 1)
    else $error("more than one chip select active");
  // floated bus stays quiet
  float_quiet_a: assert property (busFloat |-> rdN && wrN && !aleOut)
    else $error("strobe while bus floated");
  // acknowledge only once the bus is floated
  ack_float_a: assert property (bus_hold_ackOe && !bus_hold_ackOut |-> busFloat)
    else $error("hold acknowledged with bus not floated");
  // acknowledge withdrawn soon after hold goes away
  ack_release_a: assert property (
    holdN && bus_hold_ackOe && !bus_hold_ackOut |-> ##[1:8] bus_hold_ackOut)
    else $error("acknowledge kept after hold released");
  // slave mode turns the acknowledge pin into an input
  slave_input_a: assert property (
    (arbitration_enable && ack_pin_direction)[*2] |-> !bus_hold_ackOe)
    else $error("acknowledge pin driven in slave mode");
  // master mode drives the acknowledge pin
  master_drive_a: assert property ((!ack_pin_direction)[*2] |-> bus_hold_ackOe)
    else $error("acknowledge pin not driven in master mode");
  // smallest space puts out no segment lines
  seg_space_a: assert property (
    !(rdN && wrN) && addrSpaceSel == 2'h3 |-> segAddr == 8'h00)
    else $error("segment lines active in smallest space");
endmodule
bind ebc_ext_bus_ctrl ebc_bus_asserts i_ebc_bus_asserts (.*);

// [sim/ebc_ext_bus_ctrl_bench.sv]
`timescale 1ns/1ps
module ebc_ext_bus_ctrl_bench;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  logic core_clk = 0, rst = 1, clkEn = 1, reqByte = 0, readyPolHigh = 1, otherAck = 1;
  logic reqValid = 0, reqWrite = 0, reqDone, reqBusy, aleOut, rdN, wrN, readyIn, holdN = 1;
  logic bus_hold_ackOut, bus_hold_ackOe, bus_hold_ackIn, bus_request_out, busFloat, gBusy;
  logic select_timing_cfg = 0, arbitration_enable = 0, ack_pin_direction = 0;
  logic [23:0] reqAddr = 0;
  logic [15:0] reqWdata = 0, reqRdata, addrDataOut, addrDataOe, addrDataIn, address_port;
  logic [15:0] default_bus_config = 16'h3001, window1_bus_config = 16'h3002;
  logic [15:0] window2_bus_config = 16'h3001, window3_bus_config = 16'h3003;
  logic [15:0] window4_bus_config = 16'h3c01, window1_range_select = 16'h1010;
  logic [15:0] window2_range_select = 16'h0010, window3_range_select = 16'h1020;
  logic [15:0] window4_range_select = 16'h0020, gQ;
  logic [7:0]  segAddr, gSeg;
  logic [4:0]  window_chip_select_n, gCs, gAle;
  logic [1:0]  addrSpaceSel = 0, gSt;
  int          miscompares = 0, check_count = 0, gLat, baseLat, n;
  // ack pin level from whoever drives it
  assign bus_hold_ackIn = bus_hold_ackOe ? bus_hold_ackOut : otherAck;
  always #4 core_clk = ~core_clk;
  ebc_ext_bus_ctrl i_ebc_ext_bus_ctrl (.*);
  ebc_ext_mem i_ebc_ext_mem (.*);
  // ------------------------------------------
  // table: address, write, data, select pattern
  // ------------------------------------------
  typedef struct {logic [23:0] a; logic w; logic [15:0] d; logic [4:0] cs;} ebc_row_t;
  ebc_row_t rows [10] = '{'{24'h000002, 1, 16'h1111, 5'h1e}, '{24'h000002, 0, 16'h1111, 5'h1e},
    '{24'h011004, 1, 16'h2222, 5'h1d}, '{24'h011004, 0, 16'h2222, 5'h1d},
    '{24'h010006, 1, 16'h3333, 5'h1b}, '{24'h010006, 0, 16'h3333, 5'h1b},
    '{24'h021008, 1, 16'h44a4, 5'h17}, '{24'h021008, 0, 16'h00a4, 5'h17},
    '{24'h02000a, 1, 16'h5555, 5'h0f}, '{24'h02000a, 0, 16'h5555, 5'h0f}};
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one core request, held until done; records what the bus showed
  task automatic access(input logic [23:0] a, input logic w, input logic [15:0] d);
    logic prevAle;
    @(posedge core_clk);
    #1;
    reqAddr = a;
    reqWrite = w;
    reqWdata = d;
    reqValid = 1;
    {gCs, gAle, gSt, gLat, prevAle, gSeg} = {5'h1f, 5'h1f, 2'b00, 32'd0, 1'b0, 8'h00};
    gBusy = 1'b0;
    while (gLat < 200 && reqDone !== 1'b1) begin
      @(posedge core_clk);
      #1;
      gCs &= window_chip_select_n;
      gSt |= {~rdN, ~wrN};
      gBusy |= reqBusy;
      if (!(rdN && wrN)) gSeg = segAddr;
      if (aleOut && !prevAle) gAle = window_chip_select_n;
      prevAle = aleOut;
      gLat++;
    end
    chk(reqDone, 1'b1);
    gQ = reqRdata;
    reqValid = 0;
  endtask
  // bounded wait for the acknowledge pin level
  task automatic wait_ack(input logic v);
    for (n = 0; n < 30 && bus_hold_ackOut !== v; n++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------
  // sequence
  // ------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    chk({rdN, wrN, bus_hold_ackOe, window_chip_select_n}, 16'h00ff);
    #1 rst = 0;
    // table rows, plain timing
    foreach (rows[i]) begin
      access(rows[i].a, rows[i].w, rows[i].d);
      chk({gBusy, gSt}, rows[i].w ? 3'b101 : 3'b110);
      chk(gCs, rows[i].cs);
      chk(gAle, 5'h1f);
      if (!rows[i].w) chk(gQ, rows[i].d);
      if (i == 1) baseLat = gLat;
      if (i == 9) chk(16'(gLat > baseLat + 3), 16'h1);
    end
    // select already active at the ALE edge
    select_timing_cfg = 1;
    access(24'h000002, 0, 0);
    chk(gAle, 5'h1e);
    select_timing_cfg = 0;
    // longer strobe, delay and wait states
    default_bus_config = 16'h3319;
    access(24'h000002, 0, 0);
    chk(16'(gLat - baseLat), 16'h5);
    // ready active low
    default_bus_config = 16'h3001;
    window4_bus_config = 16'h3401;
    readyPolHigh = 0;
    access(24'h02000a, 0, 0);
    chk(gQ, 16'h5555);
    chk(16'(gLat > baseLat + 3), 16'h1);
    // segment lines per address space
    for (int s = 0; s < 4; s++) begin
      addrSpaceSel = s[1:0];
      access(24'hff0002, 0, 0);
      chk(gSeg, s == 3 ? 8'h00 : 8'hff >> (s ? 2 * s + 2 : 0));
    end
    addrSpaceSel = 0;
    // byte read in a 16-bit window keeps the low byte
    reqByte = 1;
    access(24'h000002, 0, 0);
    chk(gQ, 16'h0011);
    reqByte = 0;
    // 8-bit multiplexed window
    window3_bus_config = 16'h3007;
    access(24'h021008, 1, 16'h77c6);
    access(24'h021008, 0, 0);
    chk(gQ, 16'h00c6);
    // clock enable low freezes a running cycle
    fork
      access(24'h000002, 0, 0);
      begin
        repeat (2) @(posedge core_clk);
        #1 clkEn = 0;
        repeat (5) @(posedge core_clk);
        #1 clkEn = 1;
      end
    join
    chk(gQ, 16'h1111);
    chk(16'(gLat - baseLat), 16'h5);
    // single-chip: no bus cycle
    default_bus_config = 16'h0000;
    access(24'h000002, 0, 0);
    chk({gBusy, gSt, gCs}, 8'h1f);
    default_bus_config = 16'h3001;
    // hold arrives during a cycle
    arbitration_enable = 1;
    fork
      access(24'h000002, 0, 0);
      begin
        repeat (3) @(posedge core_clk);
        #1 holdN = 0;
      end
    join
    wait_ack(0);
    chk({bus_hold_ackOut, busFloat}, 2'b01);
    holdN = 1;
    wait_ack(1);
    chk(bus_hold_ackOut, 1'b1);
    // slave mode: ack pin becomes input
    ack_pin_direction = 1;
    repeat (3) @(posedge core_clk);
    #1 chk(bus_hold_ackOe, 1'b0);
    // slave asks for the bus, runs its cycle once granted
    fork
      access(24'h000004, 0, 0);
      begin
        repeat (4) @(posedge core_clk);
        #1 chk(bus_request_out, 1'b1);
        otherAck = 0;
      end
    join
    chk(gQ, 16'h2222);
    otherAck = 1;
    ack_pin_direction = 0;
    end_of_test;
  end
  // watchdog
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule

// [sim/ebc_ext_mem.sv]
`timescale 1ns/1ps
// ------------------------------------------
// external memory with ready handshake
// ------------------------------------------
module ebc_ext_mem #(
  parameter WAIT = 4  // strobe cycles before ready
) (
  // clock
  input  logic        core_clk,
  // bus side
  input  logic        aleOut,
  input  logic        rdN,
  input  logic        wrN,
  input  logic [15:0] addrDataOut,
  input  logic [15:0] addrDataOe,
  input  logic [15:0] address_port,
  input  logic        readyPolHigh,
  output logic [15:0] addrDataIn,
  output logic        readyIn
);
  logic [15:0] mem [0:15];      // word store
  logic [3:0]  idx;             // latched word index
  logic [15:0] last = 16'h0000; // last value put out
  int          waitCnt = 0;     // cycles into strobe
  // latch address from shared or dedicated port, store writes
  always @(posedge core_clk) begin
    if (aleOut)
      idx <= (addrDataOe != 16'h0000) ? addrDataOut[3:0] : address_port[3:0];
    if (!wrN)
      mem[idx] <= addrDataOut;
    if (!rdN)
      last <= mem[idx];
    waitCnt <= (rdN && wrN) ? 0 : waitCnt + 1;
  end
  // released bus shows the inverse of the last value
  assign addrDataIn = !rdN ? mem[idx] : ~last;
  // ready at chosen level after a wait; it ends only cycles whose window has ready enabled
  assign readyIn = (waitCnt >= WAIT && !(rdN && wrN)) ? readyPolHigh : !readyPolHigh;
endmodule
